// *** core/sdr_pkg.sv ***
// Shared constants for the seed and phase resync link.
package sdr_pkg;
	localparam int WORD_W = 29;
	localparam int CTRL_W = 3;
	localparam int FIELD_W = 12;
	localparam int OFFSET_W = 12;
	// Destination latches selected by the word's low control bits.
	localparam logic [2:0] ADDR_INT = 3'h0;
	localparam logic [2:0] ADDR_FRAC = 3'h1;
	localparam logic [2:0] ADDR_MODR = 3'h2;
	localparam logic [2:0] ADDR_FUNC = 3'h3;
	localparam logic [2:0] ADDR_RESYNC = 3'h4;
	// Field positions.
	localparam int RESEED_DIS_BIT = 14;
	localparam int RESYNC_HI_BIT = 20;
	localparam int RESYNC_LO_BIT = 19;
	localparam int CLKDIV_LSB = 7;
	localparam int DENOM_LSB = 3;
	localparam int OFFSET_LSB = 15;
	// Reset values and lowest legal field values.
	localparam logic [28:0] RST_WORD = 29'h0000000;
	localparam logic [11:0] RST_DENOM = 12'h002;
	localparam logic [11:0] RST_CLKDIV = 12'h001;
	localparam logic [11:0] MIN_DENOM = 12'h002;
	localparam logic [11:0] MIN_CLKDIV = 12'h001;
	// Serial clock limit and host divider.
	localparam int CORE_MHZ = 100;
	localparam int SCLK_MAX_MHZ = 20;
	localparam int SCLK_HALF = (CORE_MHZ + 2 * SCLK_MAX_MHZ - 1)
		/ (2 * SCLK_MAX_MHZ);
	localparam logic [3:0] SCLK_HALF_CNT = 4'(SCLK_HALF);
endpackage : sdr_pkg

// *** core/sdr_link_if.sv ***
// Three-wire serial link between the host and the synthesizer control.
`timescale 1ns/1ps
interface sdr_link_if;
	logic sclk;
	logic sdata;
	logic load_strobe;
	modport host (output sclk, output sdata, output load_strobe);
	modport dev (input sclk, input sdata, input load_strobe);
endinterface : sdr_link_if

// *** core/sdr_device.sv ***
// Device end: serial shift register, latches, reseed and resync timer.
// Contract
// [R1] Reseed modulator on each word-0 write unless disabled
// [R2] Host keeps offset word constant per frequency
// [R3] Resync active only when bits 20,19 are 1,0
// [R4] Sync pulses every divider times denominator periods
// [R5] Interval divider is bits 18:7, 1 to 4095
// [R6] Denominator taken from fraction word bits 14:3
// [R7] Realign on second sync after load strobe
// [R8] Host picks interval no shorter than lock
// [R9] Offset steps phase by 360 over denominator
// [R10] Capture one bit per rising serial clock
// [R11] Load strobe moves 29-bit word to latch
// [R12] Host serial clock at most 20 MHz
// [R13] Denominator accepts 2 to 4095
// [R14] Modulator and timer share comparison clock
// [R15] Low control bits pick destination latch
`timescale 1ns/1ps
module sdr_device (
	input wire logic core_clk,
	input wire logic rst_n,
	sdr_link_if.dev link,
	input wire logic cmp_tick,
	output logic seed_load,
	output logic [11:0] seed_offset,
	output logic [11:0] fractional_denominator,
	output logic resync_active,
	output logic sync_pulse,
	output logic phase_realign,
	output logic [28:0] int_word,
	output logic [28:0] fraction_config_word,
	output logic [28:0] modr_word,
	output logic [28:0] func_word,
	output logic [28:0] function_config_word
);
	// One record holds every register of this end, so the reset value and
	// the next-state copy cannot drift apart.
	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] data_s;
		logic [2:0] le_s;
		logic sclk_q;
		logic data_q;
		logic le_q;
		logic [28:0] shift;
		logic [28:0] w0;
		logic [28:0] w1;
		logic [28:0] w2;
		logic [28:0] w3;
		logic [28:0] w4;
		logic [11:0] div_cnt;
		logic [11:0] den_cnt;
		logic [1:0] sync_seen;
		logic armed;
		logic active;
		logic seed_load;
		logic sync_pulse;
		logic realign;
	} sdr_dev_state_t;

	sdr_dev_state_t r;
	sdr_dev_state_t next_r;

	// Clamp a programmed count to its lowest legal value.
	function automatic logic [11:0] sdr_clamp(input logic [11:0] v,
		input logic [11:0] lo);
		sdr_clamp = (v < lo) ? lo : v;
	endfunction : sdr_clamp

	// A pin level counts once the second and third stages agree, so an
	// edge that straddles a clock edge is taken once and never twice.
	function automatic logic sdr_settle(input logic [2:0] stages,
		input logic held);
		sdr_settle = (stages[1] == stages[2]) ? stages[2] : held;
	endfunction : sdr_settle

	// Resync enable pattern, used by the timer and by the status output.
	function automatic logic sdr_resync_on(input logic [28:0] w);
		sdr_resync_on = w[sdr_pkg::RESYNC_HI_BIT] &
			~w[sdr_pkg::RESYNC_LO_BIT];
	endfunction : sdr_resync_on

	// Helpers below are all given a value on every pass of the process, before they are read.

	logic sclk_rise;
	logic le_rise;
	logic le_level;
	logic [11:0] den;
	logic [11:0] cdiv;
	logic active;
	logic [28:0] word;

	always_comb begin
		next_r = r;
		next_r.sclk_s = {r.sclk_s[1:0], link.sclk};
		next_r.data_s = {r.data_s[1:0], link.sdata};
		next_r.le_s = {r.le_s[1:0], link.load_strobe};
		next_r.sclk_q = sdr_settle(r.sclk_s, r.sclk_q);
		next_r.data_q = sdr_settle(r.data_s, r.data_q);
		next_r.le_q = sdr_settle(r.le_s, r.le_q);
		// Edges come from the settled levels only.
		sclk_rise = next_r.sclk_q & ~r.sclk_q;
		le_rise = next_r.le_q & ~r.le_q;
		le_level = r.le_q;
		word = r.shift;
		next_r.seed_load = 1'b0;
		next_r.sync_pulse = 1'b0;
		next_r.realign = 1'b0;
		// The strobe blocks shifting: a stray clock edge while a word is
		// being latched would otherwise push a bit into the next word.
		// [R10] shift on rising
		if (sclk_rise && !le_level) begin
			next_r.shift = {r.shift[27:0], r.data_q};
		end
		// Any strobe restarts the second-sync count, even one whose address
		// no latch takes; such a word is otherwise dropped.
		// [R11] [R15] latch by address
		if (le_rise) begin
			if (word[2:0] == sdr_pkg::ADDR_INT) begin
				next_r.w0 = word;
				// The disable bit is read from the latch as it stands; one
				// strobe fills one latch, so it cannot change in this cycle.
				// [R1] reseed on write
				next_r.seed_load = ~r.w3[sdr_pkg::RESEED_DIS_BIT];
			end else if (word[2:0] == sdr_pkg::ADDR_FRAC) begin
				next_r.w1 = word;
			end else if (word[2:0] == sdr_pkg::ADDR_MODR) begin
				next_r.w2 = word;
			end else if (word[2:0] == sdr_pkg::ADDR_FUNC) begin
				next_r.w3 = word;
			end else if (word[2:0] == sdr_pkg::ADDR_RESYNC) begin
				next_r.w4 = word;
			end
			// [R7] restart sync count
			next_r.armed = 1'b1;
			next_r.sync_seen = 2'h0;
		end
		// The enable is registered from the resync word as it will stand, so
		// the status output changes in the same cycle as the latch.
		next_r.active = sdr_resync_on(next_r.w4);
		// Fields below their minimum are clamped rather than refused, so the
		// timer always has a period of at least one comparison tick.
		// [R6] [R13] denominator field
		den = sdr_clamp(r.w1[sdr_pkg::DENOM_LSB +: 12], sdr_pkg::MIN_DENOM);
		// [R5] interval divider field
		cdiv = sdr_clamp(r.w4[sdr_pkg::CLKDIV_LSB +: 12],
			sdr_pkg::MIN_CLKDIV);
		// [R3] enable pattern
		active = sdr_resync_on(r.w4);
		if (!active) begin
			next_r.div_cnt = 12'h000;
			next_r.den_cnt = 12'h000;
		// [R4] [R14] timer on comparison tick
		end else if (cmp_tick) begin
			// Compare with >= so a field lowered below the running count
			// wraps at the next tick instead of running to the counter's end.
			if (r.den_cnt >= den - 12'h001) begin
				next_r.den_cnt = 12'h000;
				if (r.div_cnt >= cdiv - 12'h001) begin
					next_r.div_cnt = 12'h000;
					next_r.sync_pulse = 1'b1;
				end else begin
					next_r.div_cnt = r.div_cnt + 12'h001;
				end
			end else begin
				next_r.den_cnt = r.den_cnt + 12'h001;
			end
		end
		// A sync pulse in the cycle of a strobe belongs to the old frequency
		// and is not counted toward the realignment.
		// [R7] second sync realigns
		if (r.sync_pulse && r.armed && !le_rise) begin
			if (r.sync_seen == 2'h1) begin
				next_r.realign = 1'b1;
				next_r.armed = 1'b0;
			end
			next_r.sync_seen = r.sync_seen + 2'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// The denominator and divider fields reset to their smallest legal values, not to zero.
			r <= '0;
			r.w1 <= {14'h0000, sdr_pkg::RST_DENOM, sdr_pkg::ADDR_FRAC};
			r.w4 <= {10'h000, sdr_pkg::RST_CLKDIV, 4'h0,
				sdr_pkg::ADDR_RESYNC};
		end else begin
			r <= next_r;
		end
	end

	assign seed_load = r.seed_load;
	// [R9] phase offset word
	assign seed_offset = r.w1[sdr_pkg::OFFSET_LSB +: 12];
	assign fractional_denominator = r.w1[sdr_pkg::DENOM_LSB +: 12];
	// The decoded enable has a flop of its own so that it leaves cleanly.
	assign resync_active = r.active;
	assign sync_pulse = r.sync_pulse;
	assign phase_realign = r.realign;
	assign int_word = r.w0;
	assign fraction_config_word = r.w1;
	assign modr_word = r.w2;
	assign func_word = r.w3;
	assign function_config_word = r.w4;
endmodule : sdr_device

// *** core/sdr_host.sv ***
// Host end: shifts a 29-bit word out MSB first, then pulses load strobe.
`timescale 1ns/1ps
module sdr_host (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic [28:0] wr_word,
	output logic wr_ready,
	output logic wr_done,
	sdr_link_if.host link
);
	typedef enum logic [1:0] {
		SDR_IDLE = 2'b00,
		SDR_LOW = 2'b01,
		SDR_HIGH = 2'b10,
		SDR_LOAD = 2'b11
	} sdr_host_st_t;

	typedef struct packed {
		sdr_host_st_t st;
		logic [28:0] sh;
		logic [4:0] bits;
		logic [3:0] cnt;
		logic sclk;
		logic sdata;
		logic le;
		logic ready;
		logic done;
	} sdr_host_state_t;

	sdr_host_state_t r;
	sdr_host_state_t next_r;
	logic tick;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		// [R12] half period divider
		tick = (r.cnt == sdr_pkg::SCLK_HALF_CNT - 4'h1);
		next_r.cnt = tick ? 4'h0 : r.cnt + 4'h1;
		case (r.st)
			SDR_IDLE: begin
				next_r.cnt = 4'h0;
				if (wr_valid && r.ready) begin
					next_r.sh = {wr_word[27:0], 1'b0};
					next_r.sdata = wr_word[28];
					next_r.bits = 5'h00;
					next_r.ready = 1'b0;
					next_r.st = SDR_LOW;
				end
			end
			SDR_LOW: begin
				if (tick) begin
					next_r.sclk = 1'b1;
					next_r.st = SDR_HIGH;
				end
			end
			SDR_HIGH: begin
				if (tick) begin
					next_r.sclk = 1'b0;
					if (r.bits == 5'h1C) begin
						next_r.st = SDR_LOAD;
					end else begin
						next_r.bits = r.bits + 5'h01;
						next_r.sdata = r.sh[28];
						next_r.sh = {r.sh[27:0], 1'b0};
						next_r.st = SDR_LOW;
					end
				end
			end
			SDR_LOAD: begin
				// The strobe stands a full half period so that the
				// device's three-stage sampler is sure to see it.
				if (!r.le) begin
					next_r.le = 1'b1;
					next_r.cnt = 4'h0;
				end else if (tick) begin
					next_r.le = 1'b0;
					next_r.ready = 1'b1;
					next_r.done = 1'b1;
					next_r.st = SDR_IDLE;
				end
			end
			default: next_r.st = SDR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign link.sclk = r.sclk;
	assign link.sdata = r.sdata;
	// [R11] strobe after word
	assign link.load_strobe = r.le;
	assign wr_ready = r.ready;
	assign wr_done = r.done;
endmodule : sdr_host

// *** tb/sdr_properties.sv ***
// Concurrent checks on the serial link and device pulses.
`timescale 1ns/1ps
module sdr_properties (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe,
	input wire logic seed_load,
	input wire logic resync_active,
	input wire logic sync_pulse,
	input wire logic phase_realign,
	input wire logic [28:0] func_word,
	input wire logic [28:0] function_config_word
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_clk_high;
		sclk [*3];
	endsequence
	sequence s_strobe_held;
		load_strobe [*3];
	endsequence
	property p_clk_half;
		$rose(sclk) |-> s_clk_high;
	endproperty
	a_clk_half: assert property (p_clk_half)
		else $error("serial clock high too short");
	property p_data_stable;
		sclk |-> $stable(sdata);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data moved while clock high");
	property p_strobe_quiet;
		load_strobe |-> !sclk;
	endproperty
	a_strobe_quiet: assert property (p_strobe_quiet)
		else $error("clock high during strobe");
	property p_strobe_len;
		$rose(load_strobe) |-> s_strobe_held;
	endproperty
	a_strobe_len: assert property (p_strobe_len)
		else $error("strobe too short");
	property p_seed_gate;
		seed_load |-> !func_word[14];
	endproperty
	a_seed_gate: assert property (p_seed_gate)
		else $error("seed loaded while disabled");
	property p_resync_dec;
		resync_active == (function_config_word[20]
			&& !function_config_word[19]);
	endproperty
	a_resync_dec: assert property (p_resync_dec)
		else $error("resync enable decode wrong");
	property p_sync_gate;
		sync_pulse |-> resync_active;
	endproperty
	a_sync_gate: assert property (p_sync_gate)
		else $error("sync pulse while inactive");
	property p_realign;
		phase_realign |-> $past(sync_pulse);
	endproperty
	a_realign: assert property (p_realign)
		else $error("realign not after sync");
endmodule : sdr_properties

// *** tb/sdm_seed_and_phase_resync_test.sv ***
// Bench joining host and device ends across the serial link.
`timescale 1ns/1ps
module sdm_seed_and_phase_resync_test;
	logic core_clk = 0, rst_n = 0, wr_valid = 0, cmp_tick = 0, ls_q = 0;
	logic [28:0] wr_word = 29'h0000000;
	logic wr_ready, wr_done, seed_load, resync_active, sync_pulse;
	logic phase_realign;
	logic [11:0] seed_offset, den;
	logic [28:0] frac_w, func_w, fcw, int_w, modr_w;
	int err_total = 0, check_count = 0, cyc = 0, seeds = 0, syncs = 0;
	int last = 0, gap = 0, real_at = -1;
	sdr_link_if link();
	sdr_host i_sdr_host (.core_clk(core_clk), .rst_n(rst_n),
		.wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
		.wr_done(wr_done), .link(link.host));
	sdr_device i_sdr_device (.core_clk(core_clk), .rst_n(rst_n),
		.link(link.dev), .cmp_tick(cmp_tick), .seed_load(seed_load),
		.seed_offset(seed_offset), .fractional_denominator(den),
		.resync_active(resync_active), .sync_pulse(sync_pulse),
		.phase_realign(phase_realign), .int_word(int_w), .modr_word(modr_w),
		.fraction_config_word(frac_w), .func_word(func_w),
		.function_config_word(fcw));
	sdr_properties i_sdr_properties (.core_clk(core_clk), .rst_n(rst_n),
		.sclk(link.sclk), .sdata(link.sdata),
		.load_strobe(link.load_strobe), .seed_load(seed_load),
		.resync_active(resync_active), .sync_pulse(sync_pulse),
		.phase_realign(phase_realign), .func_word(func_w),
		.function_config_word(fcw));
	initial forever #5 core_clk = ~core_clk;
	// A tick every other cycle stands in for the comparison clock.
	always @(posedge core_clk) cmp_tick <= ~cmp_tick;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		ls_q <= link.load_strobe;
		if (seed_load === 1'b1) seeds <= seeds + 1;
		if (link.load_strobe && !ls_q) syncs <= 0;
		else if (sync_pulse === 1'b1) syncs <= syncs + 1;
		if (sync_pulse === 1'b1) begin
			gap <= cyc - last;
			last <= cyc;
		end
		if (phase_realign === 1'b1) real_at <= syncs;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [28:0] got, input logic [28:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [28:0] w);
		int n;
		n = 0;
		@(posedge core_clk);
		wr_valid <= 1'b1;
		wr_word <= w;
		@(posedge core_clk);
		wr_valid <= 1'b0;
		while (wr_done !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 300) chk(0, 1);
		repeat (2) @(posedge core_clk);
		chk(29'(wr_ready), 29'h0000001);
	endtask : wr
	task automatic t_frac();
		wr({2'h0, 12'h007, 12'h005, sdr_pkg::ADDR_FRAC});
		chk(frac_w, {2'h0, 12'h007, 12'h005, 3'h1});
		chk(29'(den), 29'h0000005);
		chk(29'(seed_offset), 29'h0000007);
		wr({26'h0000456, sdr_pkg::ADDR_MODR});
		chk(modr_w, {26'h0000456, 3'h2});
		chk(frac_w, {2'h0, 12'h007, 12'h005, 3'h1});
		$display("frac test done");
	endtask : t_frac
	task automatic t_seed();
		int s;
		wr({14'h0, 1'h0, 11'h0, sdr_pkg::ADDR_FUNC});
		chk(func_w, 29'h0000003);
		s = seeds;
		wr({26'h0000123, sdr_pkg::ADDR_INT});
		chk(29'(seeds - s), 29'h0000001);
		chk(int_w, {26'h0000123, 3'h0});
		wr({14'h0, 1'h1, 11'h0, sdr_pkg::ADDR_FUNC});
		s = seeds;
		wr({26'h0000123, sdr_pkg::ADDR_INT});
		chk(29'(seeds - s), 29'h0000000);
		$display("seed test done");
	endtask : t_seed
	task automatic t_sync();
		int s;
		wr({8'h0, 2'h2, 12'h002, 4'h0, sdr_pkg::ADDR_RESYNC});
		chk(29'(resync_active), 29'h0000001);
		repeat (100) @(posedge core_clk);
		chk(29'(gap), 29'h0000014);
		chk(29'(real_at), 29'h0000002);
		wr({2'h0, 12'h007, 12'h001, sdr_pkg::ADDR_FRAC});
		repeat (60) @(posedge core_clk);
		chk(29'(gap), 29'h0000008);
		wr({8'h0, 2'h3, 12'h002, 4'h0, sdr_pkg::ADDR_RESYNC});
		chk(29'(resync_active), 29'h0000000);
		s = syncs;
		repeat (100) @(posedge core_clk);
		chk(29'(syncs - s), 29'h0000000);
		$display("sync test done");
	endtask : t_sync
	task automatic complete_run();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		t_frac();
		t_seed();
		t_sync();
		complete_run();
	end
endmodule : sdm_seed_and_phase_resync_test
